// ### src/tmw_pkg.sv
// package: constants and types for the 8-bit timer waveform block
package tmw_pkg;
  // ------------------------------
  // register word indices
  // ------------------------------
  localparam logic [3:0] TMW_ADDR_CTRL  = 4'h0; // modes, actions, prescale
  localparam logic [3:0] TMW_ADDR_COUNT = 4'h1; // count_value
  localparam logic [3:0] TMW_ADDR_CMPA  = 4'h2; // compare_a_value
  localparam logic [3:0] TMW_ADDR_CMPB  = 4'h3; // compare_b_value
  localparam logic [3:0] TMW_ADDR_FLAGS = 4'h4; // flags, w1c
  localparam logic [3:0] TMW_ADDR_PIN   = 4'h5; // direction bits, pin view
  // ------------------------------
  // control register field positions
  // ------------------------------
  localparam int TMW_CTRL_MODE_LSB = 0;  // wave_mode_sel [2:0]
  localparam int TMW_CTRL_PRE_LSB  = 4;  // prescale select [2:0]
  localparam int TMW_CTRL_OUTB_LSB = 8;  // out_b_action [1:0]
  localparam int TMW_CTRL_OUTA_LSB = 10; // out_a_action [1:0]
  // flag register bit positions
  localparam int TMW_FLAG_WRAP = 0;
  localparam int TMW_FLAG_MA   = 1;
  localparam int TMW_FLAG_MB   = 2;
  // ------------------------------
  // values
  // ------------------------------
  localparam logic [7:0] TMW_BOTTOM = 8'h00;
  localparam logic [7:0] TMW_MAX    = 8'hFF;
  localparam logic [2:0] TMW_MODE_PC8  = 3'h1;
  localparam logic [2:0] TMW_MODE_CTC  = 3'h2;
  localparam logic [2:0] TMW_MODE_FP8  = 3'h3;
  localparam logic [2:0] TMW_MODE_PCA  = 3'h5;
  localparam logic [2:0] TMW_MODE_FPA  = 3'h7;
  localparam logic [1:0] TMW_ACT_OFF    = 2'h0;
  localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMW_ACT_NONINV = 2'h2;
  localparam logic [1:0] TMW_ACT_INV    = 2'h3;
  // prescale selects: 0 stopped, 1..5 = /1,/8,/64,/256,/1024
  localparam logic [9:0] TMW_DIV8    = 10'h007;
  localparam logic [9:0] TMW_DIV64   = 10'h03F;
  localparam logic [9:0] TMW_DIV256  = 10'h0FF;
  localparam logic [9:0] TMW_DIV1024 = 10'h3FF;
  localparam logic [31:0] TMW_CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0]  TMW_BYTE_RESET = 8'h00;
  typedef enum logic [1:0] {TMW_BUS_IDLE, TMW_BUS_DONE} tmw_bus_t;
endpackage

// ### src/tmw_timer8.sv
// 8-bit timer with clear-on-match, fast and phase-correct pwm waveforms
//
// Notes on behaviour
// - mode 2 counts up, clears to zero on match with compare A (TOP).
// - mode 2 compare A written directly; missed match waits for wrap.
// - mode 2 sets match A flag each time count reaches TOP.
// - mode 2 with action 1 toggles output A on every match.
// - waveform reaches pin only when pin direction is output.
// - tick rate is clock divided by 1, 8, 64, 256 or 1024.
// - mode 2 sets wrap flag when count passes 0xFF to 0x00.
// - modes 3 and 7 fast pwm; TOP 0xFF or compare A.
// - fast pwm counts up to TOP, then clears on next tick.
// - fast pwm action 2 clears on match, sets at bottom; 3 inverts.
// - fast pwm action 1 with bit2 toggles only output A.
// - fast pwm sets wrap flag each time count reaches TOP.
// - fast pwm extremes: bottom gives spike, TOP gives constant level.
// - fast pwm compare writes are double buffered, toggle mode too.
// - modes 1 and 5 phase-correct; TOP 0xFF or compare A.
// - phase-correct holds TOP one tick, then counts down.
// - phase-correct: clear on up match, set on down match; 3 inverts.
// - phase-correct sets wrap flag each time count reaches bottom.
// - phase-correct action 1 with bit2 toggles output A only.
// - phase-correct compare bottom: steady low; TOP: steady high.
// - at TOP output equals up-count match result unless compare equals TOP, for symmetry.
// - counter synchronous, advances only on tick enable cycles.
// - match flag sets on next tick; write one clears it.
// - count write blocks compare matches for the following tick.
// - action 0 leaves pin to port; nonzero drives waveform.
// - phase-correct buffer updates at TOP; ctc immediate, wrap at MAX.
`timescale 1ns/1ps
module tmw_timer8
  import tmw_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             avs_response_err,
  input  wire logic        port_a_data,
  input  wire logic        port_b_data,
  output logic             pin_a_out,
  output logic             pin_a_oe_n,
  output logic             pin_b_out,
  output logic             pin_b_oe_n
);
  // ------------------------------
  // register state
  // ------------------------------
  logic [2:0]  wave_mode_sel_reg;
  logic [2:0]  pre_sel_reg;
  logic [1:0]  out_a_action_reg;
  logic [1:0]  out_b_action_reg;
  logic [7:0]  count_value_reg;
  logic [7:0]  cmp_a_buf_reg;
  logic [7:0]  cmp_b_buf_reg;
  logic [7:0]  compare_a_value_reg;
  logic [7:0]  compare_b_value_reg;
  logic        wrap_flag_reg;
  logic        match_a_flag_reg;
  logic        match_b_flag_reg;
  logic        count_down_reg;
  logic        wave_a_out_reg;
  logic        wave_b_out_reg;
  logic        dir_a_reg;
  logic        dir_b_reg;
  logic        block_reg;
  logic        pend_a_reg;
  logic        pend_b_reg;
  logic [9:0]  pre_cnt_reg;
  logic        tick_enable;
  tmw_bus_t    bus_state_reg;

  // ------------------------------
  // bus decode
  // ------------------------------
  logic wr_ok;
  logic wr_lo;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_flags;
  logic wr_pin;
  logic mapped;
  assign wr_ok    = avs_write && (bus_state_reg == TMW_BUS_DONE);
  assign wr_lo    = wr_ok && avs_byteenable[0];
  assign mapped   = (avs_address <= TMW_ADDR_PIN);
  assign wr_ctrl  = wr_ok && avs_address == TMW_ADDR_CTRL;
  assign wr_count = wr_lo && avs_address == TMW_ADDR_COUNT;
  assign wr_cmpa  = wr_lo && avs_address == TMW_ADDR_CMPA;
  assign wr_cmpb  = wr_lo && avs_address == TMW_ADDR_CMPB;
  assign wr_flags = wr_lo && avs_address == TMW_ADDR_FLAGS;
  assign wr_pin   = wr_lo && avs_address == TMW_ADDR_PIN;

  // ------------------------------
  // mode decode
  // ------------------------------
  logic       is_ctc;
  logic       is_fast;
  logic       is_pc;
  logic       wave_mode_bit2;
  logic [7:0] top_val;
  assign wave_mode_bit2 = wave_mode_sel_reg[2];
  assign is_ctc  = wave_mode_sel_reg == TMW_MODE_CTC;
  assign is_fast = wave_mode_sel_reg == TMW_MODE_FP8
                   || wave_mode_sel_reg == TMW_MODE_FPA;
  assign is_pc   = wave_mode_sel_reg == TMW_MODE_PC8
                   || wave_mode_sel_reg == TMW_MODE_PCA;
  assign top_val = (is_ctc || wave_mode_bit2) ? compare_a_value_reg
                   : TMW_MAX;

  // ------------------------------
  // bus slave: one wait state, unmapped gives error response
  // ------------------------------
  logic req_new;
  assign req_new = (avs_read || avs_write) && bus_state_reg == TMW_BUS_IDLE;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= TMW_BUS_IDLE;
    end else begin
      bus_state_reg <= req_new ? TMW_BUS_DONE : TMW_BUS_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest  <= 1'b1;
      avs_readdata     <= 32'h0000_0000;
      avs_response_err <= 1'b0;
    end else begin
      avs_waitrequest  <= !req_new;
      avs_response_err <= req_new && !mapped;
      if (req_new && avs_read) begin
        case (avs_address)
          TMW_ADDR_CTRL:  avs_readdata <= {20'h0_0000,
                            out_a_action_reg, out_b_action_reg,
                            1'b0, pre_sel_reg, 1'b0, wave_mode_sel_reg};
          TMW_ADDR_COUNT: avs_readdata <= {24'h00_0000, count_value_reg};
          TMW_ADDR_CMPA:  avs_readdata <= {24'h00_0000, cmp_a_buf_reg};
          TMW_ADDR_CMPB:  avs_readdata <= {24'h00_0000, cmp_b_buf_reg};
          TMW_ADDR_FLAGS: avs_readdata <= {29'h0000_0000, match_b_flag_reg,
                            match_a_flag_reg, wrap_flag_reg};
          TMW_ADDR_PIN:   avs_readdata <= {28'h000_0000, pin_b_out,
                            pin_a_out, dir_b_reg, dir_a_reg};
          default:        avs_readdata <= 32'h0000_0000;
        endcase
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_mode_sel_reg <= TMW_CTRL_RESET[2:0];
      pre_sel_reg       <= TMW_CTRL_RESET[2:0];
      out_a_action_reg  <= TMW_CTRL_RESET[1:0];
      out_b_action_reg  <= TMW_CTRL_RESET[1:0];
      dir_a_reg         <= 1'b0;
      dir_b_reg         <= 1'b0;
      cmp_a_buf_reg     <= TMW_BYTE_RESET;
      cmp_b_buf_reg     <= TMW_BYTE_RESET;
    end else begin
      if (wr_ctrl && avs_byteenable[0]) begin
        wave_mode_sel_reg <= avs_writedata[TMW_CTRL_MODE_LSB +: 3];
        pre_sel_reg       <= avs_writedata[TMW_CTRL_PRE_LSB +: 3];
      end
      // action changes take effect immediately, not buffered
      if (wr_ctrl && avs_byteenable[1]) begin
        out_a_action_reg <= avs_writedata[TMW_CTRL_OUTA_LSB +: 2];
        out_b_action_reg <= avs_writedata[TMW_CTRL_OUTB_LSB +: 2];
      end
      if (wr_pin) begin
        dir_a_reg <= avs_writedata[0];
        dir_b_reg <= avs_writedata[1];
      end
      if (wr_cmpa) cmp_a_buf_reg <= avs_writedata[7:0];
      if (wr_cmpb) cmp_b_buf_reg <= avs_writedata[7:0];
    end
  end

  // ------------------------------
  // prescaler
  // ------------------------------
  logic [9:0] div_mask;
  always_comb begin
    case (pre_sel_reg)
      3'h2:    div_mask = TMW_DIV8;
      3'h3:    div_mask = TMW_DIV64;
      3'h4:    div_mask = TMW_DIV256;
      3'h5:    div_mask = TMW_DIV1024;
      default: div_mask = 10'h000;
    endcase
  end
  // tick is combinational so a /1 select ticks every clock
  assign tick_enable = (pre_sel_reg != 3'h0) && (pre_sel_reg <= 3'h5)
                       && ((pre_cnt_reg & div_mask) == 10'h000);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg <= 10'h000;
    end else if (pre_sel_reg == 3'h0) begin
      pre_cnt_reg <= 10'h000;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 10'h001;
    end
  end

  // ------------------------------
  // compare and count
  // ------------------------------
  logic match_a;
  logic match_b;
  logic at_top;
  logic at_bottom;
  assign at_top    = count_value_reg == top_val;
  assign at_bottom = count_value_reg == TMW_BOTTOM;
  assign match_a = !block_reg && count_value_reg == compare_a_value_reg;
  assign match_b = !block_reg && count_value_reg == compare_b_value_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (tick_enable) begin
      block_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value_reg <= TMW_BYTE_RESET;
      count_down_reg  <= 1'b0;
    end else if (wr_count) begin
      count_value_reg <= avs_writedata[7:0];
    end else if (tick_enable) begin
      if (is_pc) begin
        if (at_top) begin
          count_down_reg  <= 1'b1;
          count_value_reg <= count_value_reg - 8'h01;
        end else if (count_down_reg && at_bottom) begin
          count_down_reg  <= 1'b0;
          count_value_reg <= count_value_reg + 8'h01;
        end else if (count_down_reg) begin
          count_value_reg <= count_value_reg - 8'h01;
        end else begin
          count_value_reg <= count_value_reg + 8'h01;
        end
      end else if (at_top && (is_fast || (is_ctc && !block_reg))) begin
        count_value_reg <= TMW_BOTTOM;
        count_down_reg  <= 1'b0;
      end else begin
        count_value_reg <= count_value_reg + 8'h01;
        count_down_reg  <= 1'b0;
      end
    end
  end

  // active compare values: direct outside pwm, buffered in pwm
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_value_reg <= TMW_BYTE_RESET;
      compare_b_value_reg <= TMW_BYTE_RESET;
    end else if (!is_pc && !is_fast) begin
      compare_a_value_reg <= cmp_a_buf_reg;
      compare_b_value_reg <= cmp_b_buf_reg;
    end else if (tick_enable && at_top) begin
      // pwm: loaded as count leaves TOP, for bottom (fast) or counting down (phase-correct)
      compare_a_value_reg <= cmp_a_buf_reg;
      compare_b_value_reg <= cmp_b_buf_reg;
    end
  end

  // ------------------------------
  // flags: match seen this tick sets flag on next tick
  // ------------------------------
  logic wrap_evt;
  assign wrap_evt = tick_enable && !wr_count && (is_fast ? at_top
                    : is_pc ? (at_bottom && count_down_reg)
                    : count_value_reg == TMW_MAX);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_a_reg <= 1'b0;
      pend_b_reg <= 1'b0;
    end else if (tick_enable) begin
      pend_a_reg <= match_a;
      pend_b_reg <= match_b;
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_flag_reg    <= 1'b0;
      match_a_flag_reg <= 1'b0;
      match_b_flag_reg <= 1'b0;
    end else begin
      wrap_flag_reg <= wrap_evt
        || (wrap_flag_reg && !(wr_flags && avs_writedata[TMW_FLAG_WRAP]));
      match_a_flag_reg <= (tick_enable && pend_a_reg)
        || (match_a_flag_reg && !(wr_flags && avs_writedata[TMW_FLAG_MA]));
      match_b_flag_reg <= (tick_enable && pend_b_reg)
        || (match_b_flag_reg && !(wr_flags && avs_writedata[TMW_FLAG_MB]));
    end
  end

  // ------------------------------
  // waveform generator
  // ------------------------------
  // next output level for one channel; can_tog false for channel b
  function automatic logic wave_next(
    input logic       cur,
    input logic [1:0] act,
    input logic       can_tog,
    input logic       hit,
    input logic       cmp_top,
    input logic       clear_on_match_mode,
    input logic       fast,
    input logic       pc,
    input logic       top,
    input logic       down,
    input logic       bit2
  );
    logic r;
    r = cur;
    if (clear_on_match_mode) begin
      if (hit) begin
        case (act)
          TMW_ACT_TOGGLE: r = !cur;
          TMW_ACT_NONINV: r = 1'b0;
          TMW_ACT_INV:    r = 1'b1;
          default:        r = cur;
        endcase
      end
    end else if (fast) begin
      if (act == TMW_ACT_TOGGLE) begin
        if (hit && can_tog && bit2) r = !cur;
      end else if (act[1]) begin
        if (top) r = !act[0];
        else if (hit && !cmp_top) r = act[0];
      end
    end else if (pc) begin
      if (act == TMW_ACT_TOGGLE) begin
        if (hit && can_tog && bit2) r = !cur;
      end else if (act[1]) begin
        if (top) r = cmp_top ^ act[0];
        else if (hit) r = down ^ act[0];
      end
    end
    return r;
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_a_out_reg <= 1'b0;
      wave_b_out_reg <= 1'b0;
    end else if (tick_enable) begin
      wave_a_out_reg <= wave_next(wave_a_out_reg, out_a_action_reg, 1'b1,
        match_a, compare_a_value_reg == top_val, is_ctc, is_fast, is_pc,
        at_top, count_down_reg && !at_bottom, wave_mode_bit2);
      wave_b_out_reg <= wave_next(wave_b_out_reg, out_b_action_reg, 1'b0,
        match_b, compare_b_value_reg == top_val, is_ctc, is_fast, is_pc,
        at_top, count_down_reg && !at_bottom, wave_mode_bit2);
    end
  end

  // ------------------------------
  // pin mux: port data synchronised, oe low while driving
  // ------------------------------
  logic [1:0] port_a_sync_reg;
  logic [1:0] port_b_sync_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_sync_reg <= 2'b00;
      port_b_sync_reg <= 2'b00;
      pin_a_out       <= 1'b0;
      pin_b_out       <= 1'b0;
      pin_a_oe_n      <= 1'b1;
      pin_b_oe_n      <= 1'b1;
    end else begin
      port_a_sync_reg <= {port_a_sync_reg[0], port_a_data};
      port_b_sync_reg <= {port_b_sync_reg[0], port_b_data};
      pin_a_out <= (out_a_action_reg != TMW_ACT_OFF) ? wave_a_out_reg
                   : port_a_sync_reg[1];
      pin_b_out <= (out_b_action_reg != TMW_ACT_OFF) ? wave_b_out_reg
                   : port_b_sync_reg[1];
      pin_a_oe_n <= !dir_a_reg;
      pin_b_oe_n <= !dir_b_reg;
    end
  end
endmodule

// ### verif/tmw_timer8_assertions.sv
// checker: bus answer timing and pin direction properties of the timer
`timescale 1ns/1ps
module tmw_timer8_chk
  import tmw_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        avs_response_err,
  input wire logic        pin_a_oe_n,
  input wire logic        pin_b_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // age of the last accepted direction write, saturating at 7
  // ------------------------------
  logic [2:0] dir_age;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_age <= 3'h7;
    end else if (avs_write && !avs_waitrequest &&
                 avs_address == TMW_ADDR_PIN) begin
      dir_age <= 3'h0;
    end else if (dir_age != 3'h7) begin
      dir_age <= dir_age + 3'h1;
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  a_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_answer_due: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[0:3] !avs_waitrequest) else $error("request left unanswered");
  a_err_map: assert property (!avs_waitrequest
    |-> avs_response_err == (avs_address > 4'h5))
    else $error("error answer does not match the address");
  a_idle_quiet: assert property (avs_waitrequest
    |-> !avs_response_err && avs_readdata == 32'h0000_0000)
    else $error("answer signals active while waiting");
  a_rd_upper: assert property (!avs_waitrequest
    |-> avs_readdata[31:12] == 20'h0_0000)
    else $error("unused read bits not zero");
  a_err_data: assert property (avs_response_err |-> avs_readdata == 0)
    else $error("error answer carries data");
  a_dir_a_cause: assert property ($changed(pin_a_oe_n)
    |-> dir_age < 3'h4) else $error("pin a direction moved without a write");
  a_dir_b_cause: assert property ($changed(pin_b_oe_n)
    |-> dir_age < 3'h4) else $error("pin b direction moved without a write");
  c_err: cover property (!avs_waitrequest && avs_response_err);
  c_dir: cover property ($fell(pin_a_oe_n));
  c_wr: cover property (avs_write && !avs_waitrequest);
endmodule

bind tmw_timer8 tmw_timer8_chk u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
  .pin_a_oe_n(pin_a_oe_n), .pin_b_oe_n(pin_b_oe_n));

// ### verif/tmw_pin_model.sv
// port pin model: pad level from the waveform driver and direction
`timescale 1ns/1ps
module tmw_pin_model (
  input  wire logic pin_a_out,
  input  wire logic pin_a_oe_n,
  input  wire logic pin_b_out,
  input  wire logic pin_b_oe_n,
  output logic      pad_a,
  output logic      pad_b
);
  // released pads sit on the pull-up, never on the last driven level
  assign pad_a = pin_a_oe_n ? 1'b1 : pin_a_out;
  assign pad_b = pin_b_oe_n ? 1'b1 : pin_b_out;
endmodule

// ### verif/timer8_waveform_modes_tb_top.sv
// testbench: waveform modes, bus access and pin gating of the timer
`timescale 1ns/1ps
module timer8_waveform_modes_tb_top;
  import tmw_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic        port_a_data = 1'b0;
  logic        port_b_data = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        avs_response_err;
  logic        pin_a_out;
  logic        pin_a_oe_n;
  logic        pin_b_out;
  logic        pin_b_oe_n;
  logic        pad_a;
  logic        pad_b;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          n_fail = 0;
  int          num_checks = 0;
  integer      seed = 66076;
  int          hi;
  int          per;
  int          hb;
  int          pb;
  int          divs[5] = '{1, 8, 64, 256, 1024};

  always #50 ref_clk = ~ref_clk;

  tmw_timer8 DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .port_a_data(port_a_data),
    .port_b_data(port_b_data), .pin_a_out(pin_a_out),
    .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n));

  tmw_pin_model u_pins (
    .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out),
    .pin_b_oe_n(pin_b_oe_n), .pad_a(pad_a), .pad_b(pad_b));

  // ------------------------------
  // reporting
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------
  // register bus master; reads leave their expectation in exp_q
  // ------------------------------
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [32:0] x);
    int k;
    k = 0;
    @(posedge ref_clk);
    if (!wr) exp_q.push_back(x);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 40) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 33'h0_0000_0000);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000, {1'b1, x});
  endtask

  task automatic cfg(input logic [2:0] m, input logic [2:0] p,
                     input logic [1:0] aa, input logic [1:0] ab);
    wr(TMW_ADDR_CTRL, {20'h0_0000, aa, ab, 1'b0, p, 1'b0, m});
  endtask

  // compares load at once only outside pwm, so load them while stopped
  task automatic setup(input logic [2:0] m, input logic [2:0] p,
    input logic [1:0] aa, input logic [1:0] ab, input logic [7:0] ca,
    input logic [7:0] cb, input logic [1:0] dr);
    cfg(TMW_MODE_CTC, 3'h0, aa, ab);
    wr(TMW_ADDR_CMPA, {24'h00_0000, ca});
    wr(TMW_ADDR_CMPB, {24'h00_0000, cb});
    wr(TMW_ADDR_COUNT, 32'h0000_0000);
    wr(TMW_ADDR_PIN, {30'h0000_0000, dr});
    wr(TMW_ADDR_FLAGS, 32'h0000_0007);
    cfg(m, p, aa, ab);
  endtask

  // ------------------------------
  // pad watching, sampled on falling edges
  // ------------------------------
  task automatic wait_lvl(input bit b, input logic v, output int n);
    n = 0;
    while ((b ? pad_b : pad_a) !== v && n < 12000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 12000) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic meas(input bit b, output int h, output int p);
    int l;
    wait_lvl(b, 1'b0, l);
    wait_lvl(b, 1'b1, l);
    wait_lvl(b, 1'b0, h);
    wait_lvl(b, 1'b1, l);
    p = h + l;
  endtask

  // an unknown level means: whatever the pad settled at
  task automatic hold(input bit b, input logic v, input string nm);
    int bad;
    logic r;
    bad = 0;
    repeat (300) @(negedge ref_clk);
    r = (v === 1'bx) ? (b ? pad_b : pad_a) : v;
    repeat (600) begin
      @(negedge ref_clk);
      if ((b ? pad_b : pad_a) !== r) bad++;
    end
    chk(nm, bad, 0);
  endtask

  task automatic late(input logic [7:0] c, output int n);
    logic l0;
    cfg(TMW_MODE_CTC, 3'h0, TMW_ACT_TOGGLE, TMW_ACT_OFF);
    wr(TMW_ADDR_COUNT, {24'h00_0000, c});
    l0 = pad_a;
    cfg(TMW_MODE_CTC, 3'h1, TMW_ACT_TOGGLE, TMW_ACT_OFF);
    wait_lvl(1'b0, !l0, n);
  endtask

  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      e = exp_q.pop_front();
      chk("err", avs_response_err, 32'(avs_address > 4'h5));
      if (e[32]) chk("readdata", avs_readdata, e[31:0]);
    end
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 7; a++) rd(4'(a), 32'h0000_0000);
    $display("reset values done");
    for (int i = 0; i < 5; i++) begin
      setup(TMW_MODE_CTC, 3'(i + 1), TMW_ACT_TOGGLE, TMW_ACT_OFF,
            8'h09, 8'hC8, 2'h1);
      meas(1'b0, hi, per);
      chk("ctc half period", hi, 10 * divs[i]);
      chk("ctc period", per, 20 * divs[i]);
    end
    rd(TMW_ADDR_FLAGS, 32'h0000_0002);
    cfg(TMW_MODE_CTC, 3'h0, TMW_ACT_TOGGLE, TMW_ACT_OFF);
    wr(TMW_ADDR_FLAGS, 32'h0000_0002);
    rd(TMW_ADDR_FLAGS, 32'h0000_0000);
    late(8'h32, hi);
    chk("missed match", 32'(hi > 150), 32'h0000_0001);
    rd(TMW_ADDR_FLAGS, 32'h0000_0007);
    late(8'h09, hi);
    chk("blocked match", 32'(hi > 150), 32'h0000_0001);
    $display("clear-on-match done");
    setup(TMW_MODE_FP8, 3'h1, TMW_ACT_NONINV, TMW_ACT_INV,
          8'h40, 8'h40, 2'h3);
    meas(1'b0, hi, per);
    meas(1'b1, hb, pb);
    chk("fast high", hi, 8'h40 + 1);
    chk("fast period", per, 256);
    chk("fast inverted", hi + hb, 256);
    rd(TMW_ADDR_FLAGS, 32'h0000_0007);
    setup(TMW_MODE_FPA, 3'h1, TMW_ACT_TOGGLE, TMW_ACT_NONINV,
          8'h63, 8'h00, 2'h3);
    meas(1'b0, hi, per);
    chk("toggle period", per, 200);
    meas(1'b1, hb, pb);
    chk("spike width", hb, 1);
    chk("spike period", pb, 100);
    setup(TMW_MODE_FPA, 3'h1, TMW_ACT_OFF, TMW_ACT_TOGGLE,
          8'h63, 8'h20, 2'h2);
    hold(1'b1, 1'bx, "b no toggle");
    setup(TMW_MODE_FP8, 3'h1, TMW_ACT_OFF, TMW_ACT_NONINV,
          8'h40, 8'hFF, 2'h2);
    hold(1'b1, 1'b1, "fast top level");
    $display("fast pwm done");
    setup(TMW_MODE_PC8, 3'h1, TMW_ACT_NONINV, TMW_ACT_INV,
          8'h40, 8'h40, 2'h3);
    meas(1'b0, hi, per);
    meas(1'b1, hb, pb);
    chk("pc high", hi, 2 * 8'h40);
    chk("pc period", per, 510);
    chk("pc inverted", hi + hb, 510);
    rd(TMW_ADDR_FLAGS, 32'h0000_0007);
    setup(TMW_MODE_PCA, 3'h1, TMW_ACT_TOGGLE, TMW_ACT_NONINV,
          8'h32, 8'h00, 2'h3);
    meas(1'b0, hi, per);
    chk("pc toggle period", per, 200);
    hold(1'b1, 1'b0, "pc bottom level");
    setup(TMW_MODE_PCA, 3'h1, TMW_ACT_OFF, TMW_ACT_NONINV,
          8'h32, 8'h32, 2'h2);
    hold(1'b1, 1'b1, "pc top level");
    $display("phase-correct done");
    setup(TMW_MODE_FP8, 3'h1, TMW_ACT_OFF, TMW_ACT_NONINV,
          8'h40, 8'h00, 2'h0);
    chk("b direction", pin_b_oe_n, 1);
    hold(1'b1, 1'b1, "released pad");
    setup(TMW_MODE_FP8, 3'h1, TMW_ACT_OFF, TMW_ACT_OFF,
          8'h40, 8'h00, 2'h3);
    repeat (8) begin
      @(posedge ref_clk);
      port_a_data <= 1'($random(seed));
      port_b_data <= 1'($random(seed));
      repeat (6) @(negedge ref_clk);
      chk("port a follow", pin_a_out, port_a_data);
      chk("port b follow", pin_b_out, port_b_data);
    end
    $display("pin control done");
    stop_test();
  end
endmodule
